// ---- rtl/dma_group_counter.sv ----
// Purpose: Counts units within a group of four for source reload.
// Assumes: Clear and increment from same-clock logic.
// Notes:   Wraps to zero after the fourth unit.
`timescale 1ns/1ps
`default_nettype none
`include "dma_reload_consts.svh"

module dma_group_counter
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       clr_i,
	input  wire logic       inc_i,
	output logic      [1:0] cnt_o,
	output logic            last_o
);

	logic [1:0] cnt_ff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// R14 clear sources win
	// R15 wrap starts new group
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clr_i)
			cnt_ff <= 2'h0;
		else if (inc_i)
			cnt_ff <= cnt_ff + 2'h1;
	end

	assign cnt_o  = cnt_ff;
	assign last_o = (cnt_ff == `GROUP_LAST);

	// R14 clear empties group
	chk_grp_clear: assert property (clr_i |=> cnt_ff == 2'h0) // R14
		else $error("group counter not cleared");

	// R15 fourth unit wraps
	chk_grp_wrap: assert property ((inc_i && !clr_i && last_o) |=> cnt_ff == 2'h0) // R15
		else $error("group counter did not wrap");

endmodule

`default_nettype wire

// ---- rtl/dma_reload_channel.sv ----
// Purpose: One DMA channel with source address reload every four units.
// Assumes: Classic Wishbone slave, one memory bus master port, one clock.
// Notes:   Software selects burst and a count divisible by four with reload.
// Function
// R1: Reload on: source address returns to its start value after every four units.
// R2: Reload on: after fourth unit of a group, stop and drop bus request.
// R3: Reload off: keep bus and continue stepping the source address.
// R4: Reload halt pulses the requester's flag clear; no clear without reload. The code also pulses it at end of count, reload on or off.
// R5: End interrupt only when count reaches zero and enable is set.
// R6: Software must use burst mode with reload.
// R7: Software must program a count divisible by four with reload.
// R8: Requester must raise a new request after each reload halt.
// R9: Burst mode keeps bus ownership between consecutive units.
// R10: Destination address steps by its own mode, never reloaded.
// R11: Byte units with increment advance both addresses by one.
// R12: Count decrements by one per unit, reload on or off.
// R13: Reload bit works only on the channel built with reload.
// R14: Group counter clears on disables, end, NMI, address error, reset, standby.
// R15: After a reload halt the next request starts a fresh group.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dma_reload_consts.svh"

module dma_reload_channel
#(
	parameter int COUNT_W    = 24,
	parameter bit HAS_RELOAD = 1'b1
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        dreq_i,
	output logic             req_flag_clr_o,
	output logic             bus_req_o,
	input  wire logic        bus_grant_i,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_adr_o,
	output logic      [1:0]  mem_size_o,
	output logic      [31:0] mem_dat_o,
	input  wire logic [31:0] mem_dat_i,
	input  wire logic        mem_ack_i,
	input  wire logic        nmi_i,
	input  wire logic        standby_i,
	output logic             irq_o
);

	generate
		if (COUNT_W < 3 || COUNT_W > 32)
		begin : g_bad
			$error("COUNT_W out of range");
		end
	endgenerate

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [31:0]             src_ff;
	logic [31:0]             start_ff;
	logic [31:0]             dst_ff;
	logic [COUNT_W-1:0]      cnt_ff;
	logic [`CC_W-1:0]        ctrl_ff;
	logic                    te_ff;
	logic                    dme_ff;
	logic                    nmif_ff;
	logic                    ae_ff;
	logic [`EV_N-1:0]        stat_ff;
	logic [`EV_N-1:0]        mask_ff;
	logic                    irq_ff;
	logic                    ack_ff;
	logic [31:0]             rd_ff;
	dma_reload_pkg::xfer_state_t st_ff;
	logic                    bus_req_ff;
	logic                    mem_req_ff;
	logic                    mem_we_ff;
	logic [31:0]             mem_adr_ff;
	logic [31:0]             mem_dat_ff;
	logic                    flag_clr_ff;
	logic                    nmi_d_ff;

	logic [1:0]              pins_s;
	logic                    nmi_s;
	logic                    standby_s;
	logic [1:0]              grp_cnt;
	logic                    grp_last;
	logic                    grp_clr;
	logic [31:0]             wmask;
	logic                    wr_en;
	logic                    wr_src;
	logic                    wr_dst;
	logic                    wr_cnt;
	logic                    wr_ctrl;
	logic                    wr_glob;
	logic                    wr_stat;
	logic                    wr_mask;
	logic                    in_step;
	logic                    ro_eff;
	logic                    run_ok;
	logic                    start_ok;
	logic                    end_hit;
	logic                    reload_now;
	logic                    halt_now;
	logic                    ae_hit;
	logic                    nmi_rise;
	logic                    mis;
	logic [`EV_N-1:0]        ev;
	logic [`CC_W-1:0]        ctrl_rd;
	dma_reload_pkg::addr_mode_t sm;
	dma_reload_pkg::addr_mode_t dm;
	dma_reload_pkg::size_t   ts;

	function automatic logic [31:0] step_addr(input logic [31:0] a,
		input dma_reload_pkg::addr_mode_t m, input dma_reload_pkg::size_t s);
		logic [31:0] inc;
		inc = 32'h0000_0001 << s;
		case (m)
			dma_reload_pkg::AM_INC: step_addr = a + inc;
			dma_reload_pkg::AM_DEC: step_addr = a - inc;
			default:                step_addr = a;
		endcase
	endfunction

	// ----------------------------------------
	// Pins and group counter
	// ----------------------------------------
	dma_sync2 #(.W(2)) u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({standby_i, nmi_i}),
		.q_o   (pins_s)
	);

	assign nmi_s     = pins_s[0];
	assign standby_s = pins_s[1];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			nmi_d_ff <= 1'b0;
		else
			nmi_d_ff <= nmi_s;
	end

	assign nmi_rise = nmi_s & ~nmi_d_ff;

	// R14 group clear sources
	assign grp_clr = ~dme_ff | ~ctrl_ff[`CC_DE] | end_hit | nmi_rise | ae_hit | standby_s;

	dma_group_counter u_grp
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (grp_clr),
		.inc_i  (in_step),
		.cnt_o  (grp_cnt),
		.last_o (grp_last)
	);

	// ----------------------------------------
	// Decode and conditions
	// ----------------------------------------
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff;
	assign wr_src  = wr_en & (wb_adr_i == `OFS_SRC);
	assign wr_dst  = wr_en & (wb_adr_i == `OFS_DST);
	assign wr_cnt  = wr_en & (wb_adr_i == `OFS_CNT);
	assign wr_ctrl = wr_en & (wb_adr_i == `OFS_CTRL);
	assign wr_glob = wr_en & (wb_adr_i == `OFS_GLOB);
	assign wr_stat = wr_en & (wb_adr_i == `OFS_STAT);
	assign wr_mask = wr_en & (wb_adr_i == `OFS_MASK);

	assign sm = dma_reload_pkg::addr_mode_t'(ctrl_ff[`CC_SM +: 2]);
	assign dm = dma_reload_pkg::addr_mode_t'(ctrl_ff[`CC_DM +: 2]);
	assign ts = dma_reload_pkg::size_t'(ctrl_ff[`CC_TS +: 2]);

	// R13 reload only where built
	assign ro_eff     = HAS_RELOAD & ctrl_ff[`CC_RO];
	assign run_ok     = dme_ff & ctrl_ff[`CC_DE] & ~nmif_ff & ~ae_ff;
	// R15 request ignored while its clear is in flight
	assign start_ok   = dreq_i & run_ok & (cnt_ff != '0) & ~te_ff & ~standby_s & ~flag_clr_ff;
	assign in_step    = (st_ff == dma_reload_pkg::ST_STEP);
	assign end_hit    = in_step & (cnt_ff == COUNT_W'(1));
	assign reload_now = in_step & ro_eff & grp_last;
	assign halt_now   = reload_now & ~end_hit;
	assign mis = ((ts == dma_reload_pkg::SZ_WORD) & (src_ff[0] | dst_ff[0]))
		| ((ts == dma_reload_pkg::SZ_LONG) & ((|src_ff[1:0]) | (|dst_ff[1:0])));
	assign ae_hit = (st_ff == dma_reload_pkg::ST_RD) & ~mem_req_ff & mis;

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_ff       <= dma_reload_pkg::ST_IDLE;
			bus_req_ff  <= 1'b0;
			mem_req_ff  <= 1'b0;
			mem_we_ff   <= 1'b0;
			mem_adr_ff  <= `ADDR_RST;
			mem_dat_ff  <= 32'h0000_0000;
			flag_clr_ff <= 1'b0;
		end
		else
		begin
			flag_clr_ff <= 1'b0;
			case (st_ff)
				dma_reload_pkg::ST_IDLE:
				begin
					if (start_ok)
					begin
						bus_req_ff <= 1'b1;
						st_ff      <= dma_reload_pkg::ST_ARB;
					end
				end
				dma_reload_pkg::ST_ARB:
				begin
					if (bus_grant_i)
						st_ff <= dma_reload_pkg::ST_RD;
				end
				dma_reload_pkg::ST_RD:
				begin
					if (!mem_req_ff)
					begin
						if (mis)
						begin
							bus_req_ff <= 1'b0;
							st_ff      <= dma_reload_pkg::ST_IDLE;
						end
						else
						begin
							mem_req_ff <= 1'b1;
							mem_we_ff  <= 1'b0;
							mem_adr_ff <= src_ff;
						end
					end
					else if (mem_ack_i)
					begin
						mem_req_ff <= 1'b0;
						mem_dat_ff <= mem_dat_i;
						st_ff      <= dma_reload_pkg::ST_WR;
					end
				end
				dma_reload_pkg::ST_WR:
				begin
					if (!mem_req_ff)
					begin
						mem_req_ff <= 1'b1;
						mem_we_ff  <= 1'b1;
						mem_adr_ff <= dst_ff;
					end
					else if (mem_ack_i)
					begin
						mem_req_ff <= 1'b0;
						mem_we_ff  <= 1'b0;
						st_ff      <= dma_reload_pkg::ST_STEP;
					end
				end
				dma_reload_pkg::ST_STEP:
				begin
					// R2 R9 halt or keep bus
					if (end_hit || halt_now || !run_ok || !ctrl_ff[`CC_BURST])
					begin
						bus_req_ff <= 1'b0;
						st_ff      <= dma_reload_pkg::ST_IDLE;
					end
					else
						st_ff <= dma_reload_pkg::ST_RD;
					// R4 requester flag clear
					flag_clr_ff <= halt_now | end_hit;
				end
				default:
				begin
					bus_req_ff <= 1'b0;
					mem_req_ff <= 1'b0;
					st_ff      <= dma_reload_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Address and count registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			src_ff   <= `ADDR_RST;
			start_ff <= `ADDR_RST;
			dst_ff   <= `ADDR_RST;
			cnt_ff   <= '0;
		end
		else
		begin
			// R1 R3 R11 source reload or step
			if (wr_src)
			begin
				src_ff   <= (src_ff & ~wmask) | (wb_dat_i & wmask);
				start_ff <= (src_ff & ~wmask) | (wb_dat_i & wmask);
			end
			else if (reload_now)
				src_ff <= start_ff;
			else if (in_step)
				src_ff <= step_addr(src_ff, sm, ts);
			// R10 destination never reloaded
			if (wr_dst)
				dst_ff <= (dst_ff & ~wmask) | (wb_dat_i & wmask);
			else if (in_step)
				dst_ff <= step_addr(dst_ff, dm, ts);
			// R12 count per unit
			if (wr_cnt)
				cnt_ff <= COUNT_W'((32'(cnt_ff) & ~wmask) | (wb_dat_i & wmask));
			else if (in_step)
				cnt_ff <= cnt_ff - COUNT_W'(1);
		end
	end

	// ----------------------------------------
	// Control and global registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_ff <= `CTRL_RST;
			te_ff   <= 1'b0;
			dme_ff  <= 1'b0;
			nmif_ff <= 1'b0;
			ae_ff   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= (ctrl_ff & ~wmask[`CC_W-1:0]) | (wb_dat_i[`CC_W-1:0] & wmask[`CC_W-1:0]);
			// Flags: set wins, cleared by writing zero
			te_ff   <= end_hit | (te_ff & ~(wr_ctrl & wb_sel_i[0] & ~wb_dat_i[`CC_TE]));
			nmif_ff <= nmi_rise | (nmif_ff & ~(wr_glob & wb_sel_i[0] & ~wb_dat_i[`GO_NMIF]));
			ae_ff   <= ae_hit | (ae_ff & ~(wr_glob & wb_sel_i[0] & ~wb_dat_i[`GO_AE]));
			if (wr_glob && wb_sel_i[0])
				dme_ff <= wb_dat_i[`GO_DME];
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	// R5 end event only with enable
	assign ev[`EV_END] = end_hit & ctrl_ff[`CC_IE];
	assign ev[`EV_AE]  = ae_hit;
	assign ev[`EV_NMI] = nmi_rise;

	genvar gi;
	generate
		for (gi = 0; gi < `EV_N; gi++)
		begin : g_stat
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					stat_ff[gi] <= 1'b0;
				else
					stat_ff[gi] <= ev[gi] | (stat_ff[gi] & ~(wr_stat & wb_sel_i[0] & wb_dat_i[gi]));
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_ff <= `MASK_RST;
			irq_ff  <= 1'b0;
		end
		else
		begin
			if (wr_mask && wb_sel_i[0])
				mask_ff <= wb_dat_i[`EV_N-1:0];
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// ----------------------------------------
	// Wishbone answer
	// ----------------------------------------
	always_comb
	begin
		ctrl_rd         = ctrl_ff;
		ctrl_rd[`CC_TE] = te_ff;
		if (!HAS_RELOAD)
			ctrl_rd[`CC_RO] = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			rd_ff  <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
			case (wb_adr_i)
				`OFS_SRC:  rd_ff <= src_ff;
				`OFS_DST:  rd_ff <= dst_ff;
				`OFS_CNT:  rd_ff <= 32'(cnt_ff);
				`OFS_CTRL: rd_ff <= 32'(ctrl_rd);
				`OFS_GLOB: rd_ff <= {29'h0, ae_ff, nmif_ff, dme_ff};
				`OFS_STAT: rd_ff <= 32'(stat_ff);
				`OFS_MASK: rd_ff <= 32'(mask_ff);
				`OFS_GRP:  rd_ff <= {30'h0, grp_cnt};
				default:   rd_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o       = ack_ff;
	assign wb_dat_o       = rd_ff;
	assign bus_req_o      = bus_req_ff;
	assign mem_req_o      = mem_req_ff;
	assign mem_we_o       = mem_we_ff;
	assign mem_adr_o      = mem_adr_ff;
	assign mem_size_o     = ctrl_ff[`CC_TS +: 2];
	assign mem_dat_o      = mem_dat_ff;
	assign req_flag_clr_o = flag_clr_ff;
	assign irq_o          = irq_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// R1 source back to start
	chk_src_reload: assert property ((reload_now && !wr_src) |=> src_ff == start_ff) // R1
		else $error("source address not reloaded");

	// R2 halt drops request
	chk_halt_release: assert property (halt_now |=> (st_ff == dma_reload_pkg::ST_IDLE) && !bus_req_o) // R2
		else $error("reload halt kept the bus");

	// R3 no reload keeps going
	chk_keep_going: assert property ((in_step && !ro_eff && ctrl_ff[`CC_BURST] && run_ok && !end_hit)
		|=> (st_ff == dma_reload_pkg::ST_RD) && bus_req_o) // R3
		else $error("transfer stopped without reload");

	// R4 flag clear tied to halt
	chk_flag_clear: assert property ((in_step && !end_hit) |=> req_flag_clr_o == $past(reload_now)) // R4
		else $error("request flag clear mismatch");

	// R5 end status needs zero count and enable
	chk_end_irq: assert property ($rose(stat_ff[`EV_END]) |-> $past(ev[`EV_END])) // R5
		else $error("end status set without cause");

	// R9 bus held through unit
	chk_bus_held: assert property ((st_ff == dma_reload_pkg::ST_RD || st_ff == dma_reload_pkg::ST_WR)
		|-> bus_req_o) // R9
		else $error("bus request dropped mid unit");

	// R10 destination not restored
	chk_dst_fixed: assert property ((reload_now && dm == dma_reload_pkg::AM_FIXED && !wr_dst)
		|=> $stable(dst_ff)) // R10
		else $error("destination changed on reload");

	// R11 byte increment by one
	chk_byte_step: assert property ((in_step && !wr_src && !reload_now && sm == dma_reload_pkg::AM_INC
		&& ts == dma_reload_pkg::SZ_BYTE) |=> src_ff == $past(src_ff) + 32'h0000_0001) // R11
		else $error("source did not advance one byte");

	// R12 count steps down by one
	chk_count_dec: assert property ((in_step && !wr_cnt) |=> cnt_ff == $past(cnt_ff) - COUNT_W'(1)) // R12
		else $error("count did not decrement");

endmodule

`default_nettype wire

// ---- rtl/dma_reload_consts.svh ----
// Purpose: Offsets, field positions and reset values of the reload DMA channel.
// Assumes: Included by bare name from rtl files.
// Notes:   Definitions only.
`ifndef DMA_RELOAD_CONSTS_SVH
`define DMA_RELOAD_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SRC   5'h00
`define OFS_DST   5'h04
`define OFS_CNT   5'h08
`define OFS_CTRL  5'h0C
`define OFS_GLOB  5'h10
`define OFS_STAT  5'h14
`define OFS_MASK  5'h18
`define OFS_GRP   5'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CC_DE     0
`define CC_TE     1
`define CC_IE     2
`define CC_RO     3
`define CC_BURST  4
`define CC_SM     5
`define CC_DM     7
`define CC_TS     9
`define CC_W      11

// ----------------------------------------
// Global register fields
// ----------------------------------------
`define GO_DME    0
`define GO_NMIF   1
`define GO_AE     2

// ----------------------------------------
// Event bits, reset values, group
// ----------------------------------------
`define EV_END    0
`define EV_AE     1
`define EV_NMI    2
`define EV_N      3
`define CTRL_RST  11'h000
`define ADDR_RST  32'h0000_0000
`define MASK_RST  3'h0
`define GROUP_LAST 2'h3

`endif

// ---- rtl/dma_reload_pkg.sv ----
// Purpose: Types shared by the reload DMA channel.
// Assumes: Nothing.
// Notes:   Constants live in dma_reload_consts.svh.
package dma_reload_pkg;

	typedef enum logic [1:0] {AM_FIXED, AM_INC, AM_DEC, AM_RSVD} addr_mode_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_RSVD} size_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_RD, ST_WR, ST_STEP} xfer_state_t;

endpackage

// ---- rtl/dma_sync2.sv ----
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs asynchronous to clk_i.
// Notes:   First stage read only by second.
`timescale 1ns/1ps
`default_nettype none

module dma_sync2
#(
	parameter int W = 2
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	generate
		if (W < 1)
		begin : g_bad
			$error("W must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;

endmodule

`default_nettype wire

// ---- tb/dma_far_side.sv ----
// Purpose: Requesting peripheral, bus arbiter and byte memory facing the channel.
// Assumes: Same clock as the channel; kick_i raises the peripheral's request flag.
// Notes:   Memory answers at once or, with slow_i, after three wait cycles.
`timescale 1ns/1ps
`default_nettype none

module dma_far_side
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        kick_i,
	input  wire logic        slow_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        bus_req_i,
	input  wire logic        flag_clr_i,
	input  wire logic        mem_req_i,
	output logic             dreq_o,
	output logic             bus_grant_o,
	output logic             mem_ack_o,
	output logic      [31:0] mem_dat_o
);
	logic       flag_ff;
	logic [1:0] wait_ff;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || flag_clr_i)
			flag_ff <= 1'b0;
		else if (kick_i)
			flag_ff <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		bus_grant_o <= !rst_i && bus_req_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mem_ack_o <= 1'b0;
			wait_ff   <= 2'h0;
		end
		else
		begin
			mem_ack_o <= 1'b0;
			if (mem_req_i && !mem_ack_o)
			begin
				if (!slow_i || wait_ff == 2'h3)
				begin
					mem_ack_o <= 1'b1;
					wait_ff   <= 2'h0;
				end
				else
					wait_ff <= wait_ff + 2'h1;
			end
		end
	end

	// Data bus shows garbage outside the answer cycle
	assign dreq_o    = flag_ff;
	assign mem_dat_o = mem_ack_o ? rdata_i : ~rdata_i;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the reload DMA channel.
// Assumes: Far side model answers memory, arbiter and request.
// Notes:   Expected memory accesses are queued by the driver.
`timescale 1ns/1ps
`default_nettype none
`include "dma_reload_consts.svh"

module testbench;
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, kick, slow, prev_req, nmi;
	logic [4:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat, wb_rd, rdata, src, dst, last_rd, seed;
	logic [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i;
	logic [1:0]  mem_size_o;
	logic        wb_ack_o, dreq, clr, bus_req_o, grant, mem_req_o, mem_we_o, mem_ack_i, irq_o;
	logic [32:0] exp_q[$];
	logic [32:0] exp_e;
	int          err_count, check_count, falls, clrs;
	logic [4:0]  rst_regs[4] = '{`OFS_CTRL, `OFS_GLOB, `OFS_MASK, `OFS_GRP};

	dma_reload_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .dreq_i(dreq), .req_flag_clr_o(clr), .bus_req_o(bus_req_o),
		.bus_grant_i(grant), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o),
		.mem_size_o(mem_size_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i),
		.nmi_i(nmi), .standby_i(1'b0), .irq_o(irq_o));

	dma_far_side i_far (.clk_i(clk_i), .rst_i(rst_i), .kick_i(kick), .slow_i(slow), .rdata_i(rdata),
		.bus_req_i(bus_req_o), .flag_clr_i(clr), .mem_req_i(mem_req_o), .dreq_o(dreq),
		.bus_grant_o(grant), .mem_ack_o(mem_ack_i), .mem_dat_o(mem_dat_i));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic kick_pulse();
		kick <= 1'b1;
		@(posedge clk_i);
		kick <= 1'b0;
	endtask

	task automatic wait_falls(input int n);
		int k;
		k = 0;
		while (falls < n && k < 3000)
		begin
			@(posedge clk_i);
			k++;
		end
		if (falls < n)
			err_count++;
		repeat (4) @(posedge clk_i);
	endtask

	// Program one run of eight byte units, increment on both sides
	task automatic arm(input logic ro, input logic [31:0] mask);
		src = xs();
		dst = xs();
		wb(1'b1, `OFS_SRC, src);
		wb(1'b1, `OFS_DST, dst);
		wb(1'b1, `OFS_CNT, 32'h0000_0008);
		wb(1'b1, `OFS_MASK, mask);
		wb(1'b1, `OFS_GLOB, 32'h0000_0001);
		for (int i = 0; i < 8; i++)
		begin
			exp_q.push_back({1'b0, src + (ro ? 32'(i % 4) : 32'(i))});
			exp_q.push_back({1'b1, dst + 32'(i)});
		end
		wb(1'b1, `OFS_CTRL, 32'h0000_00b5 | {28'h0, ro, 3'h0});
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, drivers, monitor, watchdog
	// ----------------------------------------
	always #25 clk_i = ~clk_i;

	always @(posedge clk_i)
		rdata <= xs();

	always @(posedge clk_i)
	begin
		if (!rst_i)
		begin
			if (prev_req && !bus_req_o)
				falls++;
			if (clr === 1'b1)
				clrs++;
			if (mem_req_o && mem_ack_i && !mem_we_o)
				last_rd = mem_dat_i;
			if (mem_req_o && mem_ack_i)
			begin
				exp_e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
				check("mem_access", {mem_we_o, mem_adr_o}, exp_e);
				check("mem_size", {31'h0, mem_size_o}, 33'h0);
				if (mem_we_o)
					check("mem_wdata", {1'b0, mem_dat_o}, {1'b0, last_rd});
			end
		end
		prev_req <= bus_req_o;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		{clk_i, wb_cyc, wb_stb, wb_we, kick, slow, prev_req, nmi} = '0;
		{wb_adr, wb_sel, wb_dat, rdata, last_rd} = '0;
		{err_count, check_count, falls, clrs} = '0;
		seed = 32'h0000_8b17;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (rst_regs[i])
		begin
			wb(1'b0, rst_regs[i], 32'h0);
			check("reset_reg", {1'b0, wb_rd}, 33'h0);
		end
		wb(1'b1, 5'h1e, 32'hffff_ffff);
		wb(1'b0, 5'h1e, 32'h0);
		check("unmapped", {1'b0, wb_rd}, 33'h0);
		nmi <= 1'b1;
		repeat (4) @(posedge clk_i);
		nmi <= 1'b0;
		repeat (4) @(posedge clk_i);
		wb(1'b0, `OFS_GLOB, 32'h0);
		check("nmi_flag", {1'b0, wb_rd}, 33'h2);
		wb(1'b0, `OFS_STAT, 32'h0);
		check("nmi_status", {1'b0, wb_rd}, 33'h4);
		wb(1'b1, `OFS_STAT, 32'h0000_0004);
		$display("test reset done errors=%0d", err_count);

		arm(1'b1, 32'h0000_0001);
		kick_pulse();
		wait_falls(1);
		check("clr_at_halt", 33'(clrs), 33'h1);
		check("irq_mid", {32'h0, irq_o}, 33'h0);
		wb(1'b0, `OFS_SRC, 32'h0);
		check("src_reload", {1'b0, wb_rd}, {1'b0, src});
		wb(1'b0, `OFS_DST, 32'h0);
		check("dst_step", {1'b0, wb_rd}, {1'b0, dst + 32'h4});
		wb(1'b0, `OFS_CNT, 32'h0);
		check("count_mid", {1'b0, wb_rd}, 33'h4);
		wb(1'b0, `OFS_GRP, 32'h0);
		check("group_mid", {1'b0, wb_rd}, 33'h0);
		repeat (20) @(posedge clk_i);
		check("bus_released", {32'h0, bus_req_o}, 33'h0);
		kick_pulse();
		wait_falls(2);
		check("clr_at_end", 33'(clrs), 33'h2);
		check("irq_end", {32'h0, irq_o}, 33'h1);
		wb(1'b0, `OFS_CNT, 32'h0);
		check("count_end", {1'b0, wb_rd}, 33'h0);
		wb(1'b0, `OFS_CTRL, 32'h0);
		check("end_flag", {32'h0, wb_rd[`CC_TE]}, 33'h1);
		wb(1'b1, `OFS_STAT, 32'h0000_0001);
		@(posedge clk_i);
		check("irq_cleared", {32'h0, irq_o}, 33'h0);
		check("pending", 33'(exp_q.size()), 33'h0);
		$display("test reload_on done errors=%0d", err_count);

		wb(1'b1, `OFS_CTRL, 32'h0);
		slow <= 1'b1;
		arm(1'b0, 32'h0);
		kick_pulse();
		wait_falls(3);
		check("clr_only_end", 33'(clrs), 33'h3);
		wb(1'b0, `OFS_SRC, 32'h0);
		check("src_continues", {1'b0, wb_rd}, {1'b0, src + 32'h8});
		wb(1'b0, `OFS_CNT, 32'h0);
		check("count_off", {1'b0, wb_rd}, 33'h0);
		check("bus_kept", 33'(falls), 33'h3);
		wb(1'b0, `OFS_STAT, 32'h0);
		check("status_end", {32'h0, wb_rd[`EV_END]}, 33'h1);
		check("irq_masked", {32'h0, irq_o}, 33'h0);
		check("pending", 33'(exp_q.size()), 33'h0);
		$display("test reload_off done errors=%0d", err_count);
		conclude();
	end
endmodule
`default_nettype wire
